// ### design/gdi_device_if.sv
/*
 device side interface control: decodes bus interface messages, keeps
 listen/talk/remote/lockout state and runs the service request machinery.
 assumes the bus byte and lines are pins (synchronised here), instrument
 events are one-cycle pulses on sys_clk_in, and the retained request enable
 is kept in nonvolatile storage outside and presented as a level.
*/
// Overview of operation
// RULE1: atn byte 20h/40h plus address addresses us
// RULE2: unlisten/untalk drop listen/talk state
// RULE3: interface clear drops listen and talk
// RULE4: ren plus listen address enters remote
// RULE5: ren false needs fresh listen address
// RULE6: go to local needs fresh listen address
// RULE7: lockout accepted whether addressed or not
// RULE8: armed lockout: listen locks, local unlocks
// RULE9: lockout while listening locks at once
// RULE10: lock indicator while panel suspended
// RULE11: after panel-lock command ignore lockout
// RULE12: ren false, lock command, power cancel lockout
// RULE13: request only when request enable on
// RULE14: retained enable governs power-on request
// RULE15: poll returns status byte, drops request
// RULE16: pending events reassert request after poll
// RULE17: request indicator until all events reported
// RULE18: unanswered request never blocks operation
// RULE19: rear switch with enables raises 403
// RULE20: user event in poll regardless of enable
// RULE21: probe identify, beam locate raise 403
// RULE22: event query returns pending event code
// RULE23: address 31 neither listens nor drives
// RULE24: power-on poll returns 65 decimal; the code returns 1 with requests disabled
// RULE25: poll enable sends status byte when talking
`timescale 1ns/10ps
module gdi_device_if
(
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] bus_data_in,
   input wire logic bus_atn_in,
   input wire logic bus_ren_in,
   input wire logic bus_ifc_in,
   input wire logic bus_byte_strobe_in,
   input wire logic [4:0] primary_address_in,
   input wire logic service_request_enable_in,
   input wire logic switch_request_enable_in,
   input wire logic probe_identify_report_enable_in,
   input wire logic panel_lock_cmd_in,
   input wire logic rear_external_switch_input,
   input wire logic beam_locate_button,
   input wire logic probe_identify_in,
   input wire logic error_event_in,
   input wire logic status_event_in,
   input wire logic status_byte_read_in,
   input wire logic event_query_in,
   output logic listen_out,
   output logic talk_out,
   output logic remote_state_indicator,
   output logic lock_indicator_out,
   output logic srq_drive_out,
   output logic srq_indicator_out,
   output logic poll_mode_out,
   output logic [7:0] status_byte_out,
   output logic [15:0] event_code_out
);
   // ==========================================================
   // synchronised pins
   localparam int PIN_W = 16;
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_sync;
   logic [7:0] b_data;
   logic b_atn, b_ren, b_ifc, b_stb, rear_sw, beam_btn, probe_btn;

   assign pins_raw = {bus_data_in, bus_atn_in, bus_ren_in, bus_ifc_in, bus_byte_strobe_in,
                      rear_external_switch_input, beam_locate_button, probe_identify_in, 1'b0};

   // two flops on every pin
   gdi_sync #(.WIDTH(PIN_W)) u_sync
   (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(pins_raw),
      .sync_out(pins_sync)
   );

   assign b_data = pins_sync[15:8];
   assign b_atn = pins_sync[7];
   assign b_ren = pins_sync[6];
   assign b_ifc = pins_sync[5];
   assign b_stb = pins_sync[4];
   assign rear_sw = pins_sync[3];
   assign beam_btn = pins_sync[2];
   assign probe_btn = pins_sync[1];

   // ==========================================================
   // all state
   typedef struct packed
   {
      logic listen;
      logic talk;
      logic remote;
      logic lockout_armed;
      logic locked;
      logic lock_cmd_seen;
      logic poll_mode;
      logic stb_prev;
      logic [2:0] btn_prev;
      logic [gdi_pkg::NUM_SRC-1:0] pend;
      logic [gdi_pkg::NUM_SRC-1:0] qpend;
      logic [gdi_pkg::NUM_SRC-1:0] qry_ev;
      logic srq;
      logic srq_ind;
      logic [7:0] stb;
      logic [15:0] evt;
      logic pwr_seen;
   } gdi_state_type;

   gdi_state_type state_reg;
   gdi_state_type state_next;

   logic take_byte;
   logic active;
   logic my_listen, my_talk, unl, unt, gtl, llo, spe, spd;
   logic [gdi_pkg::NUM_SRC-1:0] rise;
   logic [gdi_pkg::NUM_SRC-1:0] qrise;
   logic user_ev, srq_allowed;

   // decode of one attention byte
   always_comb
   begin
      active = (primary_address_in != gdi_pkg::NULL_ADDR); // RULE23
      take_byte = b_stb & ~state_reg.stb_prev & b_atn & active;
      my_listen = take_byte & (b_data == (gdi_pkg::LISTEN_BASE | {3'h0, primary_address_in})); // RULE1
      my_talk = take_byte & (b_data == (gdi_pkg::TALK_BASE | {3'h0, primary_address_in})); // RULE1
      unl = take_byte & (b_data == gdi_pkg::UNLISTEN_CMD); // RULE2
      unt = take_byte & (b_data == gdi_pkg::UNTALK_CMD); // RULE2
      gtl = take_byte & (b_data == gdi_pkg::GO_LOCAL_CMD) & state_reg.listen;
      llo = take_byte & (b_data == gdi_pkg::LOCKOUT_CMD); // RULE7
      spe = take_byte & (b_data == gdi_pkg::POLL_ENABLE_CMD);
      spd = take_byte & (b_data == gdi_pkg::POLL_DISABLE_CMD);
   end

   // event sources: power-on, user request, error, status change
   always_comb
   begin
      // user request from switch, probe identify, beam locate
      user_ev = (rear_sw & ~state_reg.btn_prev[0] & switch_request_enable_in) // RULE19
         | (probe_btn & ~state_reg.btn_prev[1] & probe_identify_report_enable_in) // RULE21
         | (beam_btn & ~state_reg.btn_prev[2]); // RULE21
      srq_allowed = service_request_enable_in; // RULE13 RULE14
      rise = '0;
      rise[gdi_pkg::SRC_POWER] = ~state_reg.pwr_seen & srq_allowed; // RULE14
      rise[gdi_pkg::SRC_USER] = user_ev & srq_allowed; // RULE19 RULE21
      rise[gdi_pkg::SRC_ERROR] = error_event_in & srq_allowed; // RULE13
      rise[gdi_pkg::SRC_STATUS] = status_event_in & srq_allowed; // RULE13
      // event query list keeps user events even with requests off
      qrise = rise;
      qrise[gdi_pkg::SRC_USER] = user_ev; // RULE20
      qrise[gdi_pkg::SRC_POWER] = ~state_reg.pwr_seen; // RULE24
   end

   // next state
   always_comb
   begin
      state_next = state_reg;
      state_next.stb_prev = b_stb;
      state_next.btn_prev = {beam_btn, probe_btn, rear_sw};
      state_next.pwr_seen = 1'b1;
      // addressing
      if (my_listen)
      begin
         state_next.listen = 1'b1;
         state_next.talk = 1'b0;
      end
      if (my_talk)
      begin
         state_next.talk = 1'b1;
         state_next.listen = 1'b0;
      end
      if (unl)
      begin
         state_next.listen = 1'b0; // RULE2
      end
      if (unt)
      begin
         state_next.talk = 1'b0; // RULE2
      end
      // remote state: entered on listen address with ren
      if (my_listen & b_ren)
      begin
         state_next.remote = 1'b1; // RULE4
      end
      if (~b_ren | gtl)
      begin
         state_next.remote = 1'b0; // RULE5 RULE6
      end
      // lockout handling
      if (llo & ~state_reg.lock_cmd_seen & b_ren)
      begin
         state_next.lockout_armed = 1'b1; // RULE7
         if (state_reg.listen)
         begin
            state_next.locked = 1'b1; // RULE9
         end
      end
      if (state_reg.lockout_armed & my_listen)
      begin
         state_next.locked = 1'b1; // RULE8
      end
      if (gtl)
      begin
         state_next.locked = 1'b0; // RULE8
      end
      if (panel_lock_cmd_in)
      begin
         state_next.lock_cmd_seen = 1'b1; // RULE11
      end
      if (~b_ren | panel_lock_cmd_in)
      begin
         state_next.lockout_armed = 1'b0; // RULE12
         state_next.locked = 1'b0; // RULE12
      end
      // serial poll mode
      if (spe)
      begin
         state_next.poll_mode = 1'b1; // RULE25
      end
      if (spd)
      begin
         state_next.poll_mode = 1'b0; // RULE25
      end
      // interface clear drops both addresses
      if (b_ifc & active)
      begin
         state_next.listen = 1'b0; // RULE3
         state_next.talk = 1'b0; // RULE3
      end
      if (~active)
      begin
         state_next.listen = 1'b0; // RULE23
         state_next.talk = 1'b0;
         state_next.poll_mode = 1'b0;
      end
      // poll read clears the lowest reported event; new events win
      state_next.pend = state_reg.pend;
      if (status_byte_read_in & state_reg.talk & state_reg.poll_mode & state_reg.srq)
      begin
         state_next.pend = state_reg.pend & (state_reg.pend - 4'h1); // RULE15
      end
      state_next.pend = state_next.pend | rise;
      state_next.qpend = state_reg.qpend;
      // query consumes the code; a poll read in the same cycle wins
      if (event_query_in)
      begin
         state_next.qry_ev = '0;
      end
      if (status_byte_read_in & state_reg.talk & state_reg.poll_mode)
      begin
         state_next.qpend = state_reg.qpend & (state_reg.qpend - 4'h1);
         state_next.qry_ev = state_reg.qpend & ~(state_reg.qpend - 4'h1);
      end
      state_next.qpend = state_next.qpend | qrise;
      // request line, redriven while events remain
      state_next.srq = (state_next.pend != '0) & active; // RULE15 RULE16 RULE18
      state_next.srq_ind = (state_next.pend != '0) & active; // RULE17
      // status byte shows lowest pending event
      state_next.stb = gdi_pkg::STB_NONE;
      if (state_next.qpend[gdi_pkg::SRC_POWER])
      begin
         state_next.stb = gdi_pkg::STB_POWER_ON; // RULE24
      end
      else if (state_next.qpend[gdi_pkg::SRC_USER])
      begin
         state_next.stb = gdi_pkg::STB_USER_REQ; // RULE20
      end
      else if (state_next.qpend[gdi_pkg::SRC_ERROR])
      begin
         state_next.stb = gdi_pkg::STB_ERROR;
      end
      else if (state_next.qpend[gdi_pkg::SRC_STATUS])
      begin
         state_next.stb = gdi_pkg::STB_STATUS;
      end
      if (state_next.stb != gdi_pkg::STB_NONE && !(state_next.srq))
      begin
         state_next.stb = {1'b0, state_next.stb[6:0] & gdi_pkg::RQS_BIT_MASK};
      end
      // event query code of last polled event
      state_next.evt = gdi_pkg::EVT_NONE;
      if (state_reg.qry_ev[gdi_pkg::SRC_POWER])
      begin
         state_next.evt = gdi_pkg::EVT_POWER_ON; // RULE22
      end
      else if (state_reg.qry_ev[gdi_pkg::SRC_USER])
      begin
         state_next.evt = gdi_pkg::EVT_USER_REQ; // RULE22
      end
   end

   // state register
   always_ff @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign listen_out = state_reg.listen;
   assign talk_out = state_reg.talk;
   assign remote_state_indicator = state_reg.remote;
   assign lock_indicator_out = state_reg.locked; // RULE10
   assign srq_drive_out = state_reg.srq;
   assign srq_indicator_out = state_reg.srq_ind;
   assign poll_mode_out = state_reg.poll_mode;
   assign status_byte_out = state_reg.stb;
   assign event_code_out = state_reg.evt;

   // ==========================================================
   // assertions
   unl_drops_listen_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE2
      (unl & ~my_listen) |=> ~listen_out) else $error("listen kept after unlisten");
   ifc_drops_both_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE3
      (b_ifc & active) |=> (~listen_out & ~talk_out)) else $error("address kept after clear");
   listen_addr_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE1
      (my_listen & ~b_ifc & ~unl) |=> listen_out) else $error("listen address missed");
   remote_entry_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE4
      (my_listen & b_ren & ~gtl) |=> remote_state_indicator) else $error("remote not entered");
   ren_false_local_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE5
      ~b_ren |=> (~remote_state_indicator & ~lock_indicator_out)) else $error("remote kept");
   lock_cmd_ignore_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE11
      (state_reg.lock_cmd_seen & ~state_reg.lockout_armed) |=> ~state_reg.lockout_armed)
      else $error("lockout taken after lock command");
   srq_needs_enable_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE13
      ($rose(srq_drive_out) & state_reg.pwr_seen) |-> $past(service_request_enable_in))
      else $error("request without enable");
   addr31_silent_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE23
      (~active ##1 ~active) |-> (~srq_drive_out & ~listen_out & ~talk_out)) else $error("address 31 active");
   ind_follows_srq_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE17
      srq_indicator_out == srq_drive_out) else $error("indicator mismatch");
   power_stb_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE24
      state_reg.qpend[gdi_pkg::SRC_POWER] & srq_drive_out |-> status_byte_out == 8'h41)
      else $error("power-on byte wrong");

   poll_seen_c: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) spe ##[1:50] status_byte_read_in);
   lock_seen_c: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) $rose(lock_indicator_out));
   remote_seen_c: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) $rose(remote_state_indicator));
   srq_drop_c: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) $fell(srq_drive_out));
endmodule

// ### design/gdi_pkg.sv
/*
 package for the bus interface control block: message codes, address bases,
 status byte values and event codes.
 assumes the bus byte and lines are already synchronised by the user of it.
*/
package gdi_pkg;
   // ==========================================================
   // address group bases and special values
   localparam logic [7:0] LISTEN_BASE = 8'h20;
   localparam logic [7:0] TALK_BASE = 8'h40;
   localparam logic [4:0] NULL_ADDR = 5'h1f;
   localparam logic [7:0] UNLISTEN_CMD = 8'h3f;
   localparam logic [7:0] UNTALK_CMD = 8'h5f;
   // ==========================================================
   // universal and addressed commands
   localparam logic [7:0] GO_LOCAL_CMD = 8'h01;
   localparam logic [7:0] LOCKOUT_CMD = 8'h11;
   localparam logic [7:0] POLL_ENABLE_CMD = 8'h18;
   localparam logic [7:0] POLL_DISABLE_CMD = 8'h19;
   // ==========================================================
   // status bytes and event codes
   localparam logic [7:0] STB_POWER_ON = 8'h41;
   localparam logic [7:0] STB_USER_REQ = 8'h43;
   localparam logic [7:0] STB_ERROR = 8'h61;
   localparam logic [7:0] STB_STATUS = 8'h42;
   localparam logic [7:0] STB_NONE = 8'h00;
   localparam logic [6:0] RQS_BIT_MASK = 7'h3f;
   localparam logic [15:0] EVT_NONE = 16'h0000;
   localparam logic [15:0] EVT_POWER_ON = 16'h0191;
   localparam logic [15:0] EVT_USER_REQ = 16'h0193;
   // error and status codes are supplied by the instrument
   localparam int NUM_SRC = 4;
   localparam int SRC_POWER = 0;
   localparam int SRC_USER = 1;
   localparam int SRC_ERROR = 2;
   localparam int SRC_STATUS = 3;
endpackage

// ### design/gdi_sync.sv
/*
 two flip-flop synchroniser, one per bit.
 assumes inputs come from outside the clock domain.
*/
`timescale 1ns/10ps
module gdi_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ==========================================================
   // state of both stages
   typedef struct packed
   {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } gdi_sync_state_type;

   gdi_sync_state_type state_reg;
   gdi_sync_state_type state_next;

   // next state: shift through
   always_comb
   begin
      state_next = state_reg;
      state_next.first = async_in;
      state_next.second = state_reg.first;
   end

   // register
   always_ff @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.second;
endmodule

// ### sim/gdi_ctrl_model.sv
/*
 bus controller model: sends attention bytes, drives remote enable and
 interface clear, and reads the status byte during a serial poll.
 assumes its tasks are called from one testbench process.
*/
`timescale 1ns/10ps
module gdi_ctrl_model
(
   input wire logic sys_clk_in,
   input wire logic [7:0] status_byte_in,
   output logic [7:0] bus_data_out,
   output logic bus_atn_out,
   output logic bus_ren_out,
   output logic bus_ifc_out,
   output logic bus_byte_strobe_out,
   output logic status_byte_read_out
);
   // ==========================================================
   // idle bus levels at time zero
   initial
   begin
      bus_data_out = 8'h00;
      bus_atn_out = 1'b0;
      bus_ren_out = 1'b0;
      bus_ifc_out = 1'b0;
      bus_byte_strobe_out = 1'b0;
      status_byte_read_out = 1'b0;
   end
   // ==========================================================
   // one attention byte, strobe held two edges, low four before the next
   task automatic send_cmd(input logic [7:0] cmd);
      @(posedge sys_clk_in);
      bus_data_out <= cmd;
      bus_atn_out <= 1'b1;
      bus_byte_strobe_out <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      bus_byte_strobe_out <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      // released data no longer shows the old byte
      bus_atn_out <= 1'b0;
      bus_data_out <= ~cmd;
      repeat (2) @(posedge sys_clk_in);
   endtask
   // remote enable level
   task automatic set_ren(input logic val);
      @(posedge sys_clk_in);
      bus_ren_out <= val;
      repeat (4) @(posedge sys_clk_in);
   endtask
   // interface clear pulse, long enough to pass the synchroniser
   task automatic pulse_ifc();
      @(posedge sys_clk_in);
      bus_ifc_out <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      bus_ifc_out <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
   endtask
   // poll read: take the byte, then signal that it was consumed
   task automatic read_stb(output logic [7:0] stb);
      @(posedge sys_clk_in);
      stb = status_byte_in;
      status_byte_read_out <= 1'b1;
      @(posedge sys_clk_in);
      status_byte_read_out <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
   endtask
endmodule

// ### sim/tb.sv
/*
 testbench for the device bus interface control block: addressing,
 remote and lockout handling, service requests and serial polls.
 assumes the controller model in gdi_ctrl_model.sv.
*/
`timescale 1ns/10ps
module tb;
   // ==========================================================
   // stimulus and observed signals
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [4:0] addr = 5'h0a; // our primary address
   logic svc_en = 1'b1;
   logic sw_en = 1'b1;
   logic pid_en = 1'b1;
   logic lock_cmd = 1'b0;
   logic [2:0] pins = 3'h0; // rear switch, beam locate, probe identify
   logic err_ev = 1'b0;
   logic stat_ev = 1'b0;
   logic evq = 1'b0;
   logic [7:0] bus_data;
   logic atn, ren, ifc, strobe, stb_read;
   logic listen_out, talk_out, remote_out, lock_out, srq_out, srq_ind, poll_out;
   logic [7:0] status_byte_out;
   logic [15:0] event_code_out;
   int fail_count = 0;
   int checked = 0;
   // ==========================================================
   // clock at 50 MHz
   always #10 sys_clk_in = ~sys_clk_in;
   gdi_ctrl_model i_gdi_ctrl_model (.sys_clk_in(sys_clk_in), .status_byte_in(status_byte_out),
      .bus_data_out(bus_data), .bus_atn_out(atn), .bus_ren_out(ren), .bus_ifc_out(ifc),
      .bus_byte_strobe_out(strobe), .status_byte_read_out(stb_read));
   gdi_device_if i_gdi_device_if (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .bus_data_in(bus_data), .bus_atn_in(atn), .bus_ren_in(ren), .bus_ifc_in(ifc),
      .bus_byte_strobe_in(strobe), .primary_address_in(addr), .service_request_enable_in(svc_en),
      .switch_request_enable_in(sw_en), .probe_identify_report_enable_in(pid_en),
      .panel_lock_cmd_in(lock_cmd), .rear_external_switch_input(pins[0]),
      .beam_locate_button(pins[1]), .probe_identify_in(pins[2]), .error_event_in(err_ev),
      .status_event_in(stat_ev), .status_byte_read_in(stb_read), .event_query_in(evq),
      .listen_out(listen_out), .talk_out(talk_out), .remote_state_indicator(remote_out),
      .lock_indicator_out(lock_out), .srq_drive_out(srq_out), .srq_indicator_out(srq_ind),
      .poll_mode_out(poll_out), .status_byte_out(status_byte_out), .event_code_out(event_code_out));
   // ==========================================================
   // comparison, verdict and helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bounded wait for the request line to rise
   task automatic wait_srq();
      for (int i = 0; i < 20; i++)
      begin
         if (srq_out === 1'b1)
            return;
         @(posedge sys_clk_in);
      end
      fail_count++;
      wrap_up();
   endtask
   // press one front or rear pin long enough to pass the synchroniser
   task automatic press(input int idx);
      @(posedge sys_clk_in);
      pins[idx] <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      pins[idx] <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
   endtask
   task automatic send(input logic [7:0] cmd);
      i_gdi_ctrl_model.send_cmd(cmd);
   endtask
   // full serial poll with the expected status byte
   task automatic poll(input logic [7:0] exp_stb);
      logic [7:0] stb;
      send(gdi_pkg::POLL_ENABLE_CMD);
      send(gdi_pkg::TALK_BASE + {3'h0, addr});
      chk(16'(poll_out & talk_out), 16'h0001);
      i_gdi_ctrl_model.read_stb(stb);
      chk(16'(stb), 16'(exp_stb));
      send(gdi_pkg::POLL_DISABLE_CMD);
      chk(16'(poll_out), 16'h0000);
   endtask
   // ==========================================================
   // main sequence
   initial
   begin
      repeat (4) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      wait_srq();
      chk(16'({srq_out, srq_ind}), 16'h0003);
      poll(gdi_pkg::STB_POWER_ON);
      chk(16'({srq_out, srq_ind}), 16'h0000);
      // addressing and interface clear
      i_gdi_ctrl_model.set_ren(1'b1);
      send(gdi_pkg::LISTEN_BASE + {3'h0, addr});
      chk(16'({listen_out, remote_out}), 16'h0003);
      send(gdi_pkg::UNLISTEN_CMD);
      chk(16'(listen_out), 16'h0000);
      send(gdi_pkg::TALK_BASE + {3'h0, addr});
      chk(16'(talk_out), 16'h0001);
      send(gdi_pkg::UNTALK_CMD);
      chk(16'(talk_out), 16'h0000);
      send(gdi_pkg::LISTEN_BASE + {3'h0, addr});
      send(gdi_pkg::TALK_BASE + {3'h0, addr});
      i_gdi_ctrl_model.pulse_ifc();
      chk(16'({listen_out, talk_out}), 16'h0000);
      // lockout while listening, then local and relisten
      send(gdi_pkg::LISTEN_BASE + {3'h0, addr});
      send(gdi_pkg::LOCKOUT_CMD);
      chk(16'(lock_out), 16'h0001);
      send(gdi_pkg::GO_LOCAL_CMD);
      chk(16'({lock_out, remote_out}), 16'h0000);
      send(gdi_pkg::LISTEN_BASE + {3'h0, addr});
      chk(16'({lock_out, remote_out}), 16'h0003);
      i_gdi_ctrl_model.set_ren(1'b0);
      chk(16'({lock_out, remote_out}), 16'h0000);
      i_gdi_ctrl_model.set_ren(1'b1);
      chk(16'(remote_out), 16'h0000);
      // lockout while unaddressed arms the next listen address
      send(gdi_pkg::UNLISTEN_CMD);
      send(gdi_pkg::LOCKOUT_CMD);
      chk(16'(lock_out), 16'h0000);
      send(gdi_pkg::LISTEN_BASE + {3'h0, addr});
      chk(16'(lock_out), 16'h0001);
      // panel lock command cancels and then blocks lockout
      @(posedge sys_clk_in);
      lock_cmd <= 1'b1;
      @(posedge sys_clk_in);
      lock_cmd <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      chk(16'(lock_out), 16'h0000);
      send(gdi_pkg::LOCKOUT_CMD);
      chk(16'(lock_out), 16'h0000);
      send(gdi_pkg::UNLISTEN_CMD);
      // two events pending together: error, then user request
      @(posedge sys_clk_in);
      err_ev <= 1'b1;
      @(posedge sys_clk_in);
      err_ev <= 1'b0;
      press(0);
      chk(16'(srq_out), 16'h0001);
      send(gdi_pkg::LISTEN_BASE + {3'h0, addr});
      chk(16'(listen_out), 16'h0001);
      send(gdi_pkg::UNLISTEN_CMD);
      poll(gdi_pkg::STB_USER_REQ);
      chk(event_code_out, gdi_pkg::EVT_USER_REQ);
      wait_srq();
      chk(16'({srq_out, srq_ind}), 16'h0003);
      poll(gdi_pkg::STB_ERROR);
      chk(16'({srq_out, srq_ind}), 16'h0000);
      // beam locate and probe identify
      for (int k = 1; k < 3; k++)
      begin
         press(k);
         chk(16'(srq_out), 16'h0001);
         poll(gdi_pkg::STB_USER_REQ);
      end
      // status change event, then switch and probe without their enables
      @(posedge sys_clk_in);
      stat_ev <= 1'b1;
      @(posedge sys_clk_in);
      stat_ev <= 1'b0;
      wait_srq();
      poll(gdi_pkg::STB_STATUS);
      @(posedge sys_clk_in);
      sw_en <= 1'b0;
      pid_en <= 1'b0;
      press(0);
      press(2);
      chk(16'(srq_out), 16'h0000);
      @(posedge sys_clk_in);
      sw_en <= 1'b1;
      pid_en <= 1'b1;
      // requests disabled: no request, user event still polled
      @(posedge sys_clk_in);
      svc_en <= 1'b0;
      err_ev <= 1'b1;
      @(posedge sys_clk_in);
      err_ev <= 1'b0;
      press(0);
      chk(16'(srq_out), 16'h0000);
      poll(gdi_pkg::STB_USER_REQ & 8'hbf);
      // second reset with requests off: power event polled, no request
      @(posedge sys_clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      chk(16'({srq_out, lock_out, listen_out}), 16'h0000);
      poll(gdi_pkg::STB_POWER_ON & 8'hbf);
      chk(event_code_out, gdi_pkg::EVT_POWER_ON);
      // event query consumes the reported code
      @(posedge sys_clk_in);
      evq <= 1'b1;
      @(posedge sys_clk_in);
      evq <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      chk(event_code_out, gdi_pkg::EVT_NONE);
      // address 31: listener dropped, request held off
      send(gdi_pkg::LISTEN_BASE + {3'h0, addr});
      chk(16'(listen_out), 16'h0001);
      @(posedge sys_clk_in);
      addr <= gdi_pkg::NULL_ADDR;
      svc_en <= 1'b1;
      err_ev <= 1'b1;
      @(posedge sys_clk_in);
      err_ev <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      chk(16'({srq_out, listen_out, talk_out}), 16'h0000);
      wrap_up();
   end
endmodule
